/* File: pkg/fbod_defs.svh */
// Constants of the communication object dictionary bank.
// Assumes a single 250 MHz clock and indexed access from a service-data engine.
`ifndef FBOD_DEFS_SVH
`define FBOD_DEFS_SVH

`define FBOD_IDX_ERROR_FLAGS 16'h1001
`define FBOD_IDX_ERROR_HISTORY 16'h1003
`define FBOD_IDX_PROCESS_COUNT 16'h1004
`define FBOD_IDX_SYNC_ID 16'h1005
`define FBOD_IDX_NODE_NUMBER 16'h100B
`define FBOD_IDX_GUARD_TIME 16'h100C
`define FBOD_IDX_LIFE_FACTOR 16'h100D
`define FBOD_IDX_GUARD_ID 16'h100E
`define FBOD_IDX_SERVICE_COUNT 16'h100F
`define FBOD_IDX_SAVE 16'h1010
`define FBOD_IDX_LOAD 16'h1011
`define FBOD_IDX_EMCY_ID 16'h1014
`define FBOD_IDX_IDENTITY 16'h1018

`define FBOD_HIST_DEPTH 8
`define FBOD_ID_W 11
`define FBOD_ALARM_BIT 0
`define FBOD_SYNC_CONSUMER_BIT 31
`define FBOD_SYNC_PRODUCER_BIT 30

`define FBOD_SYNC_ID_RST 11'h080
`define FBOD_GUARD_ID_BASE 11'h700
`define FBOD_EMCY_ID_BASE 11'h080
`define FBOD_GUARD_TIME_RST 16'h0000
`define FBOD_LIFE_FACTOR_RST 8'h00
`define FBOD_PROC_TOTAL 32'h0000_0002
`define FBOD_PROC_SYNC 32'h0000_0001
`define FBOD_PROC_ASYNC 32'h0000_0001
`define FBOD_SERVICE_COUNT 32'h0000_0001
`define FBOD_SAVE_CODE 32'h6576_6173
`define FBOD_LOAD_CODE 32'h6461_6F6C
`define FBOD_SAVE_CAPS 32'h0000_0001
`define FBOD_LOAD_CAPS 32'h0000_0001
`define FBOD_ARRAY_TOP_SUB 32'h0000_0001
`define FBOD_PROC_TOP_SUB 32'h0000_0002
`define FBOD_IDENT_ENTRIES 32'h0000_0004

`endif

/* File: pkg/fbod_pkg.sv */
// Types of the communication object dictionary bank.
// Assumes fbod_defs.svh is on the include path.
`include "fbod_defs.svh"
`default_nettype none
package fbod_pkg;
  typedef logic [`FBOD_HIST_DEPTH-1:0][31:0] fbod_hist_t;

  typedef struct packed {
    logic [4:0] sw_meta;
    logic [4:0] sw_sync;
    fbod_hist_t hist;
    logic [3:0] hist_count;
    logic [10:0] sync_id;
    logic [15:0] guard_time;
    logic [7:0] life_factor;
    logic [10:0] guard_id;
    logic guard_id_set;
    logic [10:0] emcy_id;
    logic emcy_id_set;
    logic defaults_pending;
    logic [23:0] life_time;
    logic rsp_valid;
    logic rsp_error;
    logic [31:0] rsp_data;
    logic save_pulse;
    logic load_pulse;
  } fbod_state_s;
endpackage
`default_nettype wire

/* File: core/fbod_dictionary.sv */
// Communication-parameter objects reached by index and subindex.
// Assumes requests, alarm and error events come from logic on i_clock;
// only the node switches and i_arst_n are asynchronous pins.
`include "fbod_defs.svh"
`default_nettype none
module fbod_dictionary #(
  parameter logic [31:0] VENDOR_CODE = 32'h0000_0A5A,  // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] REVISION_CODE = 32'h0001_0000, // Arbitrary value
  parameter logic [31:0] SERIAL_CODE = 32'h1234_5678  // Arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_index,
  input wire logic [7:0] i_req_subindex,
  input wire logic [31:0] i_req_wdata,
  input wire logic i_alarm,
  input wire logic i_error_valid,
  input wire logic [31:0] i_error_code,
  input wire logic [4:0] i_node_switch,
  input wire logic i_node_reset,
  output logic o_rsp_valid,
  output logic o_rsp_error,
  output logic [31:0] o_rsp_data,
  output logic o_save_pulse,
  output logic o_load_pulse,
  output logic [5:0] o_node_number,
  output logic [10:0] o_sync_id,
  output logic [10:0] o_guard_id,
  output logic [10:0] o_emcy_id,
  output logic [15:0] o_guard_time_ms,
  output logic [7:0] o_life_factor,
  output logic [23:0] o_life_time_ms
);
  import fbod_pkg::*;

  fbod_state_s state_reg;
  fbod_state_s state_next;
  logic [5:0] node_num;
  logic [10:0] guard_id_eff;
  logic [10:0] emcy_id_eff;
  logic [31:0] rdata;
  logic found;
  logic wr_ok;
  logic hist_clear;

  // Switch value 31 would give 32; the switches are expected to stay in 0..30
  assign node_num = {1'b0, state_reg.sw_sync} + 6'h01;
  // Until software writes them, the guard and emergency identifiers follow the node number
  assign guard_id_eff = state_reg.guard_id_set ? state_reg.guard_id
                      : `FBOD_GUARD_ID_BASE + {5'h00, node_num};
  assign emcy_id_eff = state_reg.emcy_id_set ? state_reg.emcy_id
                     : `FBOD_EMCY_ID_BASE + {5'h00, node_num};

  always_comb begin
    rdata = 32'h0000_0000;
    found = 1'b1;
    wr_ok = 1'b0;
    hist_clear = 1'b0;
    state_next = state_reg;
    state_next.sw_meta = i_node_switch;
    state_next.sw_sync = state_reg.sw_meta;
    state_next.rsp_valid = i_req_valid;
    state_next.save_pulse = 1'b0;
    state_next.load_pulse = 1'b0;

    unique case (i_req_index)
      `FBOD_IDX_ERROR_FLAGS: begin
        rdata[`FBOD_ALARM_BIT] = i_alarm;
        found = (i_req_subindex == 8'h00);
      end
      `FBOD_IDX_ERROR_HISTORY: begin
        if (i_req_subindex == 8'h00) begin
          rdata = {28'h0000000, state_reg.hist_count};
          wr_ok = (i_req_wdata == 32'h0000_0000);
          hist_clear = i_req_valid && i_req_write && wr_ok;
        end else if (i_req_subindex <= 8'(`FBOD_HIST_DEPTH)) begin
          rdata = state_reg.hist[3'(i_req_subindex - 8'h01)];
        end else begin
          found = 1'b0;
        end
      end
      `FBOD_IDX_PROCESS_COUNT: begin
        unique case (i_req_subindex)
          8'h00: rdata = `FBOD_PROC_TOTAL;
          8'h01: rdata = `FBOD_PROC_SYNC;
          8'h02: rdata = `FBOD_PROC_ASYNC;
          default: found = 1'b0;
        endcase
      end
      `FBOD_IDX_SYNC_ID: begin
        rdata[10:0] = state_reg.sync_id;
        rdata[`FBOD_SYNC_PRODUCER_BIT] = 1'b0;
        rdata[`FBOD_SYNC_CONSUMER_BIT] = 1'b1;
        found = (i_req_subindex == 8'h00);
        wr_ok = 1'b1;
      end
      `FBOD_IDX_NODE_NUMBER: begin
        rdata[5:0] = node_num;
        found = (i_req_subindex == 8'h00);
      end
      `FBOD_IDX_GUARD_TIME: begin
        rdata[15:0] = state_reg.guard_time;
        found = (i_req_subindex == 8'h00);
        wr_ok = 1'b1;
      end
      `FBOD_IDX_LIFE_FACTOR: begin
        rdata[7:0] = state_reg.life_factor;
        found = (i_req_subindex == 8'h00);
        wr_ok = 1'b1;
      end
      `FBOD_IDX_GUARD_ID: begin
        rdata[10:0] = guard_id_eff;
        found = (i_req_subindex == 8'h00);
        wr_ok = 1'b1;
      end
      `FBOD_IDX_SERVICE_COUNT: begin
        rdata = `FBOD_SERVICE_COUNT;
        found = (i_req_subindex == 8'h00);
      end
      `FBOD_IDX_SAVE: begin
        unique case (i_req_subindex)
          8'h00: rdata = `FBOD_ARRAY_TOP_SUB;
          8'h01: begin
            rdata = `FBOD_SAVE_CAPS;
            wr_ok = (i_req_wdata == `FBOD_SAVE_CODE);
          end
          default: found = 1'b0;
        endcase
      end
      `FBOD_IDX_LOAD: begin
        unique case (i_req_subindex)
          8'h00: rdata = `FBOD_ARRAY_TOP_SUB;
          8'h01: begin
            rdata = `FBOD_LOAD_CAPS;
            wr_ok = (i_req_wdata == `FBOD_LOAD_CODE);
          end
          default: found = 1'b0;
        endcase
      end
      `FBOD_IDX_EMCY_ID: begin
        rdata[10:0] = emcy_id_eff;
        found = (i_req_subindex == 8'h00);
        wr_ok = 1'b1;
      end
      `FBOD_IDX_IDENTITY: begin
        unique case (i_req_subindex)
          8'h00: rdata = `FBOD_IDENT_ENTRIES;
          8'h01: rdata = VENDOR_CODE;
          8'h02: rdata = PRODUCT_CODE;
          8'h03: rdata = REVISION_CODE;
          8'h04: rdata = SERIAL_CODE;
          default: found = 1'b0;
        endcase
      end
      default: found = 1'b0;
    endcase

    if (i_req_valid) begin
      state_next.rsp_data = i_req_write ? 32'h0000_0000 : rdata;
      state_next.rsp_error = !found || (i_req_write && !wr_ok);
    end

    if (i_req_valid && i_req_write && found && wr_ok) begin
      unique case (i_req_index)
        `FBOD_IDX_SYNC_ID: state_next.sync_id = i_req_wdata[10:0];
        `FBOD_IDX_GUARD_TIME: state_next.guard_time = i_req_wdata[15:0];
        `FBOD_IDX_LIFE_FACTOR: state_next.life_factor = i_req_wdata[7:0];
        `FBOD_IDX_GUARD_ID: begin
          state_next.guard_id = i_req_wdata[10:0];
          state_next.guard_id_set = 1'b1;
        end
        `FBOD_IDX_EMCY_ID: begin
          state_next.emcy_id = i_req_wdata[10:0];
          state_next.emcy_id_set = 1'b1;
        end
        `FBOD_IDX_SAVE: state_next.save_pulse = 1'b1;
        `FBOD_IDX_LOAD: begin
          state_next.load_pulse = 1'b1;
          state_next.defaults_pending = 1'b1;
        end
        default: state_next.defaults_pending = state_reg.defaults_pending;
      endcase
    end

    // Clear first so an error landing in the same cycle survives it
    if (hist_clear) begin
      state_next.hist = '0;
      state_next.hist_count = 4'h0;
    end
    if (i_error_valid) begin
      for (int k = `FBOD_HIST_DEPTH - 1; k > 0; k--) begin
        state_next.hist[k] = hist_clear ? 32'h0000_0000 : state_reg.hist[k-1];
      end
      state_next.hist[0] = i_error_code;
      if (hist_clear) begin
        state_next.hist_count = 4'h1;
      end else if (state_reg.hist_count < 4'(`FBOD_HIST_DEPTH)) begin
        state_next.hist_count = state_reg.hist_count + 4'h1;
      end else begin
        state_next.hist_count = 4'(`FBOD_HIST_DEPTH);
      end
    end

    // Defaults from a load wait for the node reset, as the master expects
    if (i_node_reset && state_reg.defaults_pending) begin
      state_next.sync_id = `FBOD_SYNC_ID_RST;
      state_next.guard_time = `FBOD_GUARD_TIME_RST;
      state_next.life_factor = `FBOD_LIFE_FACTOR_RST;
      state_next.guard_id_set = 1'b0;
      state_next.emcy_id_set = 1'b0;
      // A load taken in the same cycle stays pending for the next node reset
      state_next.defaults_pending = state_next.load_pulse;
    end

    // Widen both operands first so the product keeps all 24 bits
    state_next.life_time = 24'(state_reg.life_factor) * 24'(state_reg.guard_time);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
      state_reg.sync_id <= `FBOD_SYNC_ID_RST;
      state_reg.guard_time <= `FBOD_GUARD_TIME_RST;
      state_reg.life_factor <= `FBOD_LIFE_FACTOR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Only the sync identifier and emergency identifier here are meant for the save image
  assign o_rsp_valid = state_reg.rsp_valid;
  assign o_rsp_error = state_reg.rsp_error;
  assign o_rsp_data = state_reg.rsp_data;
  assign o_save_pulse = state_reg.save_pulse;
  assign o_load_pulse = state_reg.load_pulse;
  assign o_node_number = node_num;
  assign o_sync_id = state_reg.sync_id;
  assign o_guard_id = guard_id_eff;
  assign o_emcy_id = emcy_id_eff;
  assign o_guard_time_ms = state_reg.guard_time;
  assign o_life_factor = state_reg.life_factor;
  assign o_life_time_ms = state_reg.life_time;
endmodule
`default_nettype wire

/* File: dv/fbod_monitor.sv */
// Port-level checks for the dictionary bank.
// Assumes a bind into fbod_dictionary and one clock domain.
`default_nettype none
module fbod_monitor (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_index,
  input wire logic [7:0] i_req_subindex,
  input wire logic [31:0] i_req_wdata,
  input wire logic i_alarm,
  input wire logic [4:0] i_node_switch,
  input wire logic o_rsp_valid,
  input wire logic [31:0] o_rsp_data,
  input wire logic [10:0] o_guard_id,
  input wire logic [10:0] o_emcy_id,
  input wire logic o_save_pulse,
  input wire logic o_load_pulse,
  input wire logic [5:0] o_node_number,
  input wire logic [10:0] o_sync_id,
  input wire logic [15:0] o_guard_time_ms,
  input wire logic [7:0] o_life_factor,
  input wire logic [23:0] o_life_time_ms
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  wire logic rd = i_req_valid && !i_req_write;
  wire logic wr = i_req_valid && i_req_write;
  // All four bytes must match, so a near miss never fires a pulse
  wire logic save_hit = wr && i_req_index == 16'h1010 && i_req_subindex == 8'h01
    && i_req_wdata == 32'h6576_6173;
  wire logic load_hit = wr && i_req_index == 16'h1011 && i_req_subindex == 8'h01
    && i_req_wdata == 32'h6461_6F6C;
  a_alarm_flag: assert property (
    rd && i_req_index == 16'h1001 |=> o_rsp_data[0] == $past(i_alarm)) else $error("alarm bit");
  a_proc_total: assert property (
    rd && i_req_index == 16'h1004 && i_req_subindex == 8'h00 |=> o_rsp_data == 32'h2)
    else $error("channel total");
  a_sync_flags: assert property (
    rd && i_req_index == 16'h1005 |=> o_rsp_data[31:11] == 21'h10_0000) else $error("sync flags");
  a_sync_write: assert property (
    wr && i_req_index == 16'h1005 && i_req_subindex == 8'h00
    |=> o_sync_id == 11'($past(i_req_wdata))) else $error("sync id");
  // Switches pass two flops, so only a settled value is judged
  a_node_calc: assert property (
    $stable(i_node_switch)[*3] ##0 $past(i_arst_n, 3) |-> o_node_number == i_node_switch + 6'h01)
    else $error("node number");
  a_life_prod: assert property (
    o_life_time_ms == $past(o_life_factor) * $past(o_guard_time_ms)) else $error("life time");
  a_save_gate: assert property (
    o_save_pulse == $past(save_hit)) else $error("save pulse");
  a_load_gate: assert property (
    o_load_pulse == $past(load_hit)) else $error("load pulse");
  a_rsp_pulse: assert property (
    o_rsp_valid == $past(i_req_valid)) else $error("response strobe");
  a_guard_port: assert property (
    rd && i_req_index == 16'h100E |=> o_rsp_data == {21'h00_0000, $past(o_guard_id)})
    else $error("guard id port");
  a_emcy_port: assert property (
    rd && i_req_index == 16'h1014 |=> o_rsp_data == {21'h00_0000, $past(o_emcy_id)})
    else $error("emergency id port");
  c_save: cover property (o_save_pulse);
  c_load: cover property (o_load_pulse);
  c_clear: cover property (wr && i_req_index == 16'h1003);
endmodule
bind fbod_dictionary fbod_monitor mon (.*);
`default_nettype wire

/* File: dv/fbod_master.sv */
// Service-data master model: one indexed request per call.
// Assumes drive on the falling edge and an answer one cycle later.
`default_nettype none
module fbod_master (
  input wire logic i_clock,
  output logic o_req_valid = 1'b0,
  output logic o_req_write = 1'b0,
  output logic [15:0] o_req_index = 16'h0000,
  output logic [7:0] o_req_subindex = 8'h00,
  output logic [31:0] o_req_wdata = 32'h0000_0000,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_error,
  input wire logic [31:0] i_rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines are inverted once released so that no stale value can pass for a live one
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic [31:0] rdata, output logic err);
    @(negedge i_clock);
    o_req_valid = 1'b1;
    o_req_write = w;
    o_req_index = idx;
    o_req_subindex = sub;
    o_req_wdata = wd;
    @(negedge i_clock);
    o_req_valid = 1'b0;
    o_req_write = ~w;
    o_req_index = ~idx;
    o_req_subindex = ~sub;
    o_req_wdata = ~wd;
    rdata = i_rsp_valid ? i_rsp_data : 32'hXXXX_XXXX;
    err = i_rsp_valid ? i_rsp_error : 1'bx;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the dictionary bank.
// Assumes the design, master model and monitor are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] IDV = 128'h0000_00D4_0000_00C3_0000_00B2_0000_00A1; // Arbitrary
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic alarm = 1'b0;
  logic err_valid = 1'b0;
  logic [31:0] err_code = 32'h0;
  logic node_rst = 1'b0;
  logic [4:0] node_sw = 5'h04;
  logic req_valid, req_write, rsp_valid, rsp_error;
  logic [15:0] req_index;
  logic [7:0] req_sub;
  logic [31:0] req_wdata, rsp_data;
  logic [23:0] life_time;
  int fails = 0;
  int samples_checked = 0;
  fbod_master m (.i_clock(clk), .o_req_valid(req_valid), .o_req_write(req_write),
    .o_req_index(req_index), .o_req_subindex(req_sub), .o_req_wdata(req_wdata),
    .i_rsp_valid(rsp_valid), .i_rsp_error(rsp_error), .i_rsp_data(rsp_data));
  fbod_dictionary #(.VENDOR_CODE(IDV[31:0]), .PRODUCT_CODE(IDV[63:32]),
    .REVISION_CODE(IDV[95:64]), .SERIAL_CODE(IDV[127:96])) dut (
    .i_clock(clk), .i_arst_n(arst_n), .i_req_valid(req_valid), .i_req_write(req_write),
    .i_req_index(req_index), .i_req_subindex(req_sub), .i_req_wdata(req_wdata),
    .i_alarm(alarm), .i_error_valid(err_valid), .i_error_code(err_code),
    .i_node_switch(node_sw), .i_node_reset(node_rst), .o_rsp_valid(rsp_valid),
    .o_rsp_error(rsp_error), .o_rsp_data(rsp_data), .o_save_pulse(), .o_load_pulse(),
    .o_node_number(), .o_sync_id(), .o_guard_id(), .o_emcy_id(), .o_guard_time_ms(),
    .o_life_factor(), .o_life_time_ms(life_time));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    m.xfer(1'b0, idx, sub, 32'h0, d, e);
    chk(d, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                    input logic exp_err);
    logic [31:0] d;
    logic e;
    m.xfer(1'b1, idx, sub, wd, d, e);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic push(input logic [31:0] code);
    @(negedge clk);
    err_valid = 1'b1;
    err_code = code;
    @(negedge clk);
    err_valid = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    rd(16'h1005, 8'h00, 32'h8000_0080);
    rd(16'h100B, 8'h00, 32'h5);
    rd(16'h100E, 8'h00, 32'h705);
    rd(16'h1014, 8'h00, 32'h85);
    rd(16'h100D, 8'h00, 32'h0);
    rd(16'h100F, 8'h00, 32'h1);
    rd(16'h1010, 8'h01, 32'h1);
    rd(16'h1011, 8'h01, 32'h1);
    for (int k = 0; k < 3; k++) rd(16'h1004, 8'(k), k == 0 ? 32'h2 : 32'h1);
    rd(16'h1018, 8'h00, 32'h4);
    for (int k = 1; k < 5; k++) rd(16'h1018, 8'(k), IDV[32*k-32 +: 32]);
    wr(16'h1018, 8'h01, 32'h0, 1'b1);
    alarm = 1'b1;
    rd(16'h1001, 8'h00, 32'h1);
    alarm = 1'b0;
    rd(16'h1001, 8'h00, 32'h0);
    rd(16'h1003, 8'h00, 32'h0);
    for (int k = 1; k < 10; k++) begin
      push(32'hE000_0000 + 32'(k));
      if (k == 2) rd(16'h1003, 8'h02, 32'hE000_0001);
    end
    rd(16'h1003, 8'h00, 32'h8);
    rd(16'h1003, 8'h01, 32'hE000_0009);
    rd(16'h1003, 8'h08, 32'hE000_0002);
    wr(16'h1003, 8'h01, 32'h0, 1'b1);
    wr(16'h1003, 8'h00, 32'h1, 1'b1);
    wr(16'h1003, 8'h00, 32'h0, 1'b0);
    rd(16'h1003, 8'h00, 32'h0);
    wr(16'h100C, 8'h00, 32'h1234, 1'b0);
    wr(16'h100D, 8'h00, 32'hFF, 1'b0);
    rd(16'h100C, 8'h00, 32'h1234);
    chk({8'h0, life_time}, 32'h1234 * 32'hFF);
    wr(16'h1010, 8'h01, 32'h6576_6174, 1'b1);
    wr(16'h1010, 8'h01, 32'h6576_6173, 1'b0);
    wr(16'h1005, 8'h00, 32'h181, 1'b0);
    wr(16'h100E, 8'h00, 32'hFFFF_FF23, 1'b0);
    rd(16'h100E, 8'h00, 32'h723);
    wr(16'h1014, 8'h00, 32'h4000_0095, 1'b0);
    rd(16'h1014, 8'h00, 32'h95);
    wr(16'h1011, 8'h01, 32'h6461_6F6D, 1'b1);
    wr(16'h1011, 8'h01, 32'h6461_6F6C, 1'b0);
    rd(16'h1005, 8'h00, 32'h8000_0181);
    @(negedge clk);
    node_rst = 1'b1;
    @(negedge clk);
    node_rst = 1'b0;
    rd(16'h1005, 8'h00, 32'h8000_0080);
    rd(16'h100C, 8'h00, 32'h0);
    rd(16'h100E, 8'h00, 32'h705);
    // Switches pass two flops, so give them a few cycles to settle
    node_sw = 5'h1E;
    repeat (4) @(negedge clk);
    rd(16'h100B, 8'h00, 32'h1F);
    rd(16'h1014, 8'h00, 32'h9F);
    report_and_stop();
  end
  // About 130 cycles are needed; this allows ample margin
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
